/* verilog/arop_regs.svh */
// register offsets, field positions, reset values of the result port
// assumes 8-bit apb byte addresses and 32-bit data
`ifndef AROP_REGS_SVH
`define AROP_REGS_SVH

`define AROP_CTRL_OFS    8'h00
`define AROP_STAT_OFS    8'h04
`define AROP_RES_OFS     8'h08

`define AROP_C_SERIAL    0
`define AROP_C_EXTCLK    1
`define AROP_C_RDDUR     2
`define AROP_C_SCLKPOL   3
`define AROP_C_MARKPOL   4
`define AROP_C_CODING    5
`define AROP_CTRL_W      6
`define AROP_CTRL_RST    6'h20

`define AROP_S_BUSY      0
`define AROP_S_LATE      1
`define AROP_S_MACT      2
`define AROP_S_UNREAD    3

`define AROP_NBITS       16
`define AROP_NBITS_W     5
`define AROP_QTR_DIV     2

`endif

/* verilog/arop_pkg.sv */
// types shared by the result port modules
// assumes arop_regs.svh for the numeric constants
package arop_pkg;
  typedef enum logic [1:0] {
    M_IDLE  = 2'b01,
    M_SHIFT = 2'b10
  } arop_mstate_t;
endpackage

/* verilog/arop_link_if.sv */
// signals between the system-clock logic and the external shift clock logic
// assumes clk and rst_n are driven by the system side
`timescale 1ns/1ps
interface arop_link_if;
  logic        clk;
  logic        rst_n;
  logic [15:0] word;
  logic        abort_tgl;
  logic        chain_in;
  logic        ser_out;
  logic        active;
  logic        done;
  modport sys  (output clk, rst_n, word, abort_tgl, chain_in,
                input  ser_out, active, done);
  modport link (input  clk, rst_n, word, abort_tgl, chain_in,
                output ser_out, active, done);
endinterface

/* verilog/arop_slave_shift.sv */
// slave-mode shifter on the host shift clock
// assumes the clock is the host clock with polarity applied, reset while deselected
`timescale 1ns/1ps
`include "arop_regs.svh"
module arop_slave_shift import arop_pkg::*; (
  arop_link_if.link lk
);
  logic [15:0]             sh_q, sh_d;
  logic [`AROP_NBITS_W-1:0] cnt_q, cnt_d;
  logic                    out_q, out_d;
  logic                    act_q, act_d;
  logic                    lost_q, lost_d;
  logic                    ab_s1_q, ab_s2_q;

  // --------------------------------------------------
  // shift path
  // --------------------------------------------------
  always_comb begin
    sh_d   = {sh_q[14:0], lk.chain_in};
    out_d  = sh_q[15];
    act_d  = 1'b1;
    cnt_d  = cnt_q;
    lost_d = lost_q | ab_s2_q;
    if (!act_q) begin
      sh_d = {lk.word[14:0], lk.chain_in};
      out_d = lk.word[15];
    end
    if (cnt_q != `AROP_NBITS_W'(`AROP_NBITS)) begin
      cnt_d = cnt_q + `AROP_NBITS_W'(1);
    end
    if (lost_d && (cnt_q < `AROP_NBITS_W'(`AROP_NBITS))) begin
      out_d = 1'b0;
    end
  end

  always_ff @(posedge lk.clk or negedge lk.rst_n) begin
    if (!lk.rst_n) begin
      sh_q    <= 16'h0000;
      cnt_q   <= '0;
      out_q   <= 1'b0;
      act_q   <= 1'b0;
      lost_q  <= 1'b0;
      ab_s1_q <= 1'b0;
      ab_s2_q <= 1'b0;
    end else begin
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      out_q   <= out_d;
      act_q   <= act_d;
      lost_q  <= lost_d;
      ab_s1_q <= lk.abort_tgl;
      ab_s2_q <= ab_s1_q;
    end
  end

  assign lk.ser_out = out_q;
  assign lk.active  = act_q;
  assign lk.done    = cnt_q[`AROP_NBITS_W-1];
endmodule

/* verilog/arop_top.sv */
// result output port: parallel bus or serial master/slave, apb control
// assumes a converter core on sys_clk giving start/done pulses and a result
//
// Notes on behaviour
// - parallel mode drives shared pins 8 to 11 as result bits
// - slave mode passes chain input to serial output sixteen clocks later
// - master mode sends during next conversion or after conversion per mode bit
// - result shifted out most significant bit first, coding per select
// - master data stable across both shift clock edges
// - slave data changes on active edge chosen by clock polarity
// - shift clock pin is output with internal clock, input otherwise
// - master frame marker active while serial data valid, polarity selectable
// - slave read unfinished at next conversion end loses data, pulses flag
// - pins 12 to 15 stay outputs in every mode
// - busy high from conversion start until result latched
// - port style select picks parallel or serial pin use
// - coding select high gives straight binary, low inverts msb
// - output drivers enabled only while chip select and read both low
// - clock source low makes clock internally, high uses host clock
`timescale 1ns/1ps
`include "arop_regs.svh"
module arop_top import arop_pkg::*; #(
  parameter int unsigned QTR_DIV = `AROP_QTR_DIV
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_start,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        chain_in,
  input  wire logic        shift_clk_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe,
  output logic             busy
);
  localparam int unsigned DW = $clog2(QTR_DIV + 1);

  arop_link_if lk ();

  logic                  cs_s1_q, cs_s2_q;
  logic                  rd_s1_q, rd_s2_q;
  logic                  act_s1_q, act_s2_q;
  logic                  dn_s1_q, dn_s2_q;
  logic [`AROP_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic                  late_q, late_d;
  logic [31:0]           prdata_q, prdata_d;
  logic                  pready_q, pready_d;
  logic                  pslverr_q, pslverr_d;
  logic                  busy_q, busy_d;
  logic [15:0]           result_q, result_d;
  logic                  unread_q, unread_d;
  logic                  lpulse_q, lpulse_d;
  logic                  abort_q, abort_d;
  arop_mstate_t          ms_q, ms_d;
  logic [DW-1:0]         div_q, div_d;
  logic [1:0]            ph_q, ph_d;
  logic [3:0]            bit_q, bit_d;
  logic [15:0]           mw_q, mw_d;
  logic                  sclk_q, sclk_d;
  logic                  sdo_q, sdo_d;
  logic                  mark_q, mark_d;
  logic [15:0]           pout_q, pout_d;
  logic [15:0]           poe_q, poe_d;

  logic serial, extclk, rddur, sclkpol, markpol, coding;
  logic master, slave, en, rd_open, m_done, tick;
  logic acc, wr;

  assign serial  = ctrl_q[`AROP_C_SERIAL];
  assign extclk  = ctrl_q[`AROP_C_EXTCLK];
  assign rddur   = ctrl_q[`AROP_C_RDDUR];
  assign sclkpol = ctrl_q[`AROP_C_SCLKPOL];
  assign markpol = ctrl_q[`AROP_C_MARKPOL];
  assign coding  = ctrl_q[`AROP_C_CODING];
  assign master  = serial & ~extclk;
  assign slave   = serial & extclk;
  assign en      = ~cs_s2_q & ~rd_s2_q;
  assign rd_open = act_s2_q & ~dn_s2_q;

  // --------------------------------------------------
  // pin and crossing synchronisers
  // --------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      rd_s1_q  <= 1'b1;
      rd_s2_q  <= 1'b1;
      act_s1_q <= 1'b0;
      act_s2_q <= 1'b0;
      dn_s1_q  <= 1'b0;
      dn_s2_q  <= 1'b0;
    end else begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      rd_s1_q  <= rd_n;
      rd_s2_q  <= rd_s1_q;
      act_s1_q <= lk.active;
      act_s2_q <= act_s1_q;
      dn_s1_q  <= lk.done;
      dn_s2_q  <= dn_s1_q;
    end
  end

  // --------------------------------------------------
  // apb slave, one wait state
  // --------------------------------------------------
  assign acc = psel & penable & ~pready_q;
  assign wr  = psel & penable & pready_q & pwrite & ~pslverr_q;

  always_comb begin
    ctrl_d    = ctrl_q;
    late_d    = late_q;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    pready_d  = acc;
    if (acc) begin
      unique case (paddr)
        `AROP_CTRL_OFS: prdata_d[`AROP_CTRL_W-1:0] = ctrl_q;
        `AROP_STAT_OFS: begin
          prdata_d[`AROP_S_BUSY]   = busy_q;
          prdata_d[`AROP_S_LATE]   = late_q;
          prdata_d[`AROP_S_MACT]   = (ms_q == M_SHIFT);
          prdata_d[`AROP_S_UNREAD] = unread_q;
        end
        `AROP_RES_OFS: prdata_d[15:0] = result_q;
        default: pslverr_d = 1'b1;
      endcase
      if (pwrite) begin
        prdata_d = 32'h0000_0000;
      end
    end
    if (wr && (paddr == `AROP_CTRL_OFS)) begin
      ctrl_d = pwdata[`AROP_CTRL_W-1:0];
    end
    if (wr && (paddr == `AROP_STAT_OFS) && pwdata[`AROP_S_LATE]) begin
      late_d = 1'b0;
    end
    if (lpulse_d) begin
      late_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= `AROP_CTRL_RST;
      late_q    <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      late_q    <= late_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // --------------------------------------------------
  // conversion result, busy, late read
  // --------------------------------------------------
  always_comb begin
    busy_d   = busy_q;
    result_d = result_q;
    unread_d = unread_q;
    lpulse_d = 1'b0;
    abort_d  = abort_q & act_s2_q;
    if (conv_start) begin
      busy_d = 1'b1;
    end
    if (m_done || (slave && dn_s2_q)) begin
      unread_d = 1'b0;
    end
    if (conv_done) begin
      busy_d   = 1'b0;
      result_d = {conv_result[15] ^ ~coding, conv_result[14:0]};
      unread_d = 1'b1;
      if (slave && rd_open) begin
        lpulse_d = 1'b1;
        abort_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q   <= 1'b0;
      result_q <= 16'h0000;
      unread_q <= 1'b0;
      lpulse_q <= 1'b0;
      abort_q  <= 1'b0;
    end else begin
      busy_q   <= busy_d;
      result_q <= result_d;
      unread_q <= unread_d;
      lpulse_q <= lpulse_d;
      abort_q  <= abort_d;
    end
  end

  // --------------------------------------------------
  // serial master: four ticks per bit
  // --------------------------------------------------
  assign tick   = (div_q == DW'(QTR_DIV - 1));
  assign m_done = (ms_q == M_SHIFT) & tick & (ph_q == 2'd3) & (bit_q == 4'hf);

  always_comb begin
    ms_d   = ms_q;
    div_d  = div_q;
    ph_d   = ph_q;
    bit_d  = bit_q;
    mw_d   = mw_q;
    sclk_d = sclk_q;
    sdo_d  = sdo_q;
    mark_d = mark_q;
    unique case (ms_q)
      M_IDLE: begin
        div_d = '0;
        ph_d  = 2'd0;
        bit_d = 4'h0;
        if (master && en && ((rddur && conv_start) ||
            (!rddur && !busy_q && unread_q))) begin
          ms_d   = M_SHIFT;
          mw_d   = result_q;
          sdo_d  = result_q[15];
          mark_d = 1'b1;
        end
      end
      M_SHIFT: begin
        div_d = tick ? '0 : div_q + DW'(1);
        if (tick) begin
          ph_d = ph_q + 2'd1;
          if (ph_q == 2'd0) begin
            sclk_d = 1'b1;
          end
          if (ph_q == 2'd2) begin
            sclk_d = 1'b0;
          end
          if (ph_q == 2'd3) begin
            bit_d = bit_q + 4'h1;
            sdo_d = mw_q[4'he - bit_q];
            if (bit_q == 4'hf) begin
              ms_d   = M_IDLE;
              sdo_d  = 1'b0;
              mark_d = 1'b0;
            end
          end
        end
      end
      default: begin
        ms_d   = M_IDLE;
        sclk_d = 1'b0;
        mark_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ms_q   <= M_IDLE;
      div_q  <= '0;
      ph_q   <= 2'd0;
      bit_q  <= 4'h0;
      mw_q   <= 16'h0000;
      sclk_q <= 1'b0;
      sdo_q  <= 1'b0;
      mark_q <= 1'b0;
    end else begin
      ms_q   <= ms_d;
      div_q  <= div_d;
      ph_q   <= ph_d;
      bit_q  <= bit_d;
      mw_q   <= mw_d;
      sclk_q <= sclk_d;
      sdo_q  <= sdo_d;
      mark_q <= mark_d;
    end
  end

  // --------------------------------------------------
  // pin muxing and drivers
  // --------------------------------------------------
  always_comb begin
    pout_d = result_q;
    poe_d  = {16{en}};
    if (serial) begin
      pout_d[7:0]   = 8'h00;
      poe_d[7:0]    = 8'h00;
      pout_d[8]     = sdo_q;
      pout_d[9]     = sclk_q ^ sclkpol;
      poe_d[9]      = en & ~extclk;
      pout_d[10]    = mark_q ^ markpol;
      poe_d[10]     = en & ~extclk;
      pout_d[11]    = lpulse_q;
      poe_d[11]     = en & extclk;
      pout_d[15:12] = result_q[15:12];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pout_q <= 16'h0000;
      poe_q  <= 16'h0000;
    end else begin
      pout_q <= pout_d;
      poe_q  <= poe_d;
    end
  end

  // --------------------------------------------------
  // slave shifter on the host clock
  // --------------------------------------------------
  assign lk.clk       = shift_clk_in ^ sclkpol;
  assign lk.rst_n     = resetn & ~cs_n & slave;
  assign lk.word      = result_q;
  assign lk.abort_tgl = abort_q;
  assign lk.chain_in  = chain_in;

  arop_slave_shift u_slave (
    .lk (lk.link)
  );

  assign pin_out = {pout_q[15:9], slave ? lk.ser_out : pout_q[8], pout_q[7:0]};
  assign pin_oe  = poe_q;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign busy    = busy_q;
endmodule

/* verification/arop_host.sv */
// host serial reader model: makes the shift clock, feeds the chain input
// assumes the bench selects the device before go and holds it until idle
`timescale 1ns/1ps
module arop_host (
  input  wire logic        go,
  input  wire logic        pol,
  input  wire logic [5:0]  nclk,
  input  wire logic [15:0] chain_word,
  input  wire logic        sdo,
  output logic             sclk,
  output logic             chain,
  output logic             busy_h,
  output logic      [31:0] got
);
  initial begin
    sclk = 1'b0;
    chain = 1'b0;
    busy_h = 1'b0;
    got = '0;
    forever begin
      @(posedge go);
      busy_h = 1'b1;
      sclk = pol; // host drives the clock, idle at inactive level
      chain = chain_word[15];
      #37;
      for (int i = 0; i < nclk; i++) begin
        #16 sclk = !pol; // active edge, device updates data
        #16 sclk = pol; // next edge, host samples
        got = {got[30:0], sdo};
        chain <= (i < 15) ? chain_word[14-i] : !chain; // chain data
      end
      #1 chain = !chain;
      busy_h = 1'b0;
    end
  end
endmodule

/* verification/arop_sva.sv */
// checker of the result port pins, busy and serial framing
// assumes it is bound into arop_top and sees only its ports
`timescale 1ns/1ps
`include "arop_regs.svh"
module arop_sva #(
  parameter int unsigned QTR_DIV = 2
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [15:0] conv_result,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        chain_in,
  input wire logic        shift_clk_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic        busy
);
  logic [5:0] ctrl_q;
  logic [4:0] rise_q;
  logic       sck_q;
  wire        ser = ctrl_q[`AROP_C_SERIAL];
  wire        mst = ser && !ctrl_q[`AROP_C_EXTCLK];
  wire        slv = ser && ctrl_q[`AROP_C_EXTCLK];
  wire        mark = pin_out[10] ^ ctrl_q[`AROP_C_MARKPOL];
  // ------------------------------------------------------------
  // shadow of the control register, shift clock rises per frame
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `AROP_CTRL_RST;
      rise_q <= '0;
      sck_q <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && !pslverr && paddr == `AROP_CTRL_OFS) begin
        ctrl_q <= pwdata[5:0];
      end
      sck_q <= pin_out[9];
      rise_q <= !mark ? 5'h0 : rise_q + 5'(pin_out[9] && !sck_q);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_busy_rise; conv_start |=> busy; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");
  property p_busy_hold; busy && !conv_done |=> busy; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_busy_fall; $fell(busy) |-> $past(conv_done); endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell without done");
  property p_quiet; (cs_n || rd_n) [*5] |-> pin_oe == 16'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("pins driven while deselected");
  property p_hi_pins; pin_oe[8] |-> pin_oe[15:12] == 4'hf; endproperty
  a_hi_pins: assert property (p_hi_pins) else $error("upper pins not driven");
  property p_mdata; mst && pin_oe[9] && $rose(pin_out[9]) |-> $stable(pin_out[8]); endproperty
  a_mdata: assert property (p_mdata) else $error("data moved at clock edge");
  property p_sclk_dir; ser && pin_oe[8] |-> pin_oe[9] == !ctrl_q[`AROP_C_EXTCLK]; endproperty
  a_sclk_dir: assert property (p_sclk_dir) else $error("shift clock direction wrong");
  property p_frame; mst && pin_oe[10] && $past(pin_oe[10]) && $fell(mark) |-> rise_q == 5'h10; endproperty
  a_frame: assert property (p_frame) else $error("frame without sixteen clocks");
  property p_late_one; slv && pin_oe[11] && $rose(pin_out[11]) |=> !pin_out[11]; endproperty
  a_late_one: assert property (p_late_one) else $error("late flag not a pulse");
  property p_late_why; slv && pin_oe[11] && $rose(pin_out[11]) |-> $past(conv_done, 2); endproperty
  a_late_why: assert property (p_late_why) else $error("late flag without done");
  c_frame: cover property (mst && pin_oe[10] && $fell(mark));
  c_late: cover property (slv && $rose(pin_out[11]));
  c_busy: cover property ($fell(busy));
endmodule
bind arop_top arop_sva #(.QTR_DIV(QTR_DIV)) u_sva (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_done, .conv_result, .cs_n, .rd_n, .chain_in,
  .shift_clk_in, .pin_out, .pin_oe, .busy);

/* verification/adc_result_output_port_test.sv */
// testbench of the result port: apb, parallel, serial master and slave reads
// assumes arop_top, the arop_host model and the bound checker
`timescale 1ns/1ps
`include "arop_regs.svh"
module adc_result_output_port_test;
  logic        sys_clk = '0, resetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic        conv_start = '0, conv_done = '0, cs_n = '1, rd_n = '1, go = '0, pol = '0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, got;
  logic [15:0] conv_result = '0, pin_out, pin_oe, chw = '0, mw = '0;
  logic [5:0]  nclk = '0;
  logic        pready, pslverr, busy, sclk, chain, hbusy, er, sck_q = '0, lt_q = '0;
  int          fail_count = 0, comparisons = 0, mc = 0, lp = 0;
  wire         sdo = pin_oe[8] ? pin_out[8] : 1'bz;
  arop_top #(.QTR_DIV(1)) dut (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .conv_start, .conv_done, .conv_result, .cs_n, .rd_n, .chain_in(chain),
    .shift_clk_in(sclk), .pin_out, .pin_oe, .busy);
  arop_host host (.go, .pol, .nclk, .chain_word(chw), .sdo, .sclk, .chain, .busy_h(hbusy), .got);
  initial forever #12.5 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // master frame capture, late flag pulses
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    sck_q <= pin_out[9];
    lt_q <= pin_out[11];
    if (pin_oe[11] && pin_out[11] && !lt_q) lp <= lp + 1;
    if (pin_oe[9] && pin_out[9] && !sck_q) begin
      mw <= {mw[14:0], pin_out[8]};
      mc <= mc + 1;
    end
  end
  task automatic chk(input logic [31:0] a, e);
    comparisons++;
    if (a !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t: %h not %h", $time, a, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conv(input logic [15:0] r, input int len);
    @(posedge sys_clk);
    conv_start <= 1'b1;
    @(posedge sys_clk);
    conv_start <= 1'b0;
    repeat (len) @(posedge sys_clk);
    chk(busy, 1);
    conv_result <= r;
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    @(posedge sys_clk);
    chk(busy, 0);
  endtask
  task automatic sel(input logic s);
    @(posedge sys_clk);
    cs_n <= !s;
    rd_n <= !s;
    repeat (5) @(posedge sys_clk);
  endtask
  function automatic logic [15:0] coded(input logic [15:0] r, input logic ob);
    return ob ? r : {~r[15], r[14:0]};
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    give_verdict;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] r, r0;
    logic        ob;
    void'($urandom(32'h28c23c43));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(0, `AROP_CTRL_OFS, 0);
    chk(q, `AROP_CTRL_RST);
    apb(0, 8'h0c, 0);
    chk(er, 1);
    for (int i = 0; i < 2; i++) begin
      r = 16'($urandom);
      ob = i[0];
      apb(1, `AROP_CTRL_OFS, {ob, 5'h0});
      conv(r, 5);
      apb(0, `AROP_RES_OFS, 0);
      chk(q, coded(r, ob));
      sel(1);
      chk(pin_oe, 16'hffff);
      chk(pin_out, coded(r, ob));
      sel(0);
      chk(pin_oe, 0);
    end
    for (int i = 0; i < 4; i++) begin
      r0 = 16'($urandom);
      r = 16'($urandom);
      ob = 1'($urandom);
      apb(1, `AROP_CTRL_OFS, {ob, i[1], i[1] ^ i[0], i[0], 2'b01});
      conv(r0, 5);
      mc = 0;
      sel(1);
      if (i[0]) conv(r, 90);
      repeat (90) @(posedge sys_clk);
      chk(mc, 16);
      chk(mw, coded(r0, ob));
      sel(0);
    end
    for (int i = 0; i < 3; i++) begin
      r = 16'($urandom);
      chw <= 16'($urandom);
      ob = 1'($urandom);
      pol <= i[0];
      nclk <= (i == 2) ? 6'h5 : 6'h20;
      apb(1, `AROP_CTRL_OFS, {ob, 1'b0, i[0], 3'b011});
      conv(r, 5);
      sel(1);
      lp = 0;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      wait (!hbusy);
      if (i < 2) chk(got, {coded(r, ob), chw});
      else begin
        conv(r, 5);
        repeat (4) @(posedge sys_clk);
        chk(lp, 1);
        nclk <= 6'hb;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        wait (!hbusy);
        chk(got[7:0], 0);
        apb(0, `AROP_STAT_OFS, 0);
        chk(q[`AROP_S_LATE], 1);
        apb(1, `AROP_STAT_OFS, 32'h1 << `AROP_S_LATE);
        apb(0, `AROP_STAT_OFS, 0);
        chk(q[`AROP_S_LATE], 0);
      end
      sel(0);
    end
    give_verdict;
  end
endmodule
